// [hw/synth_divider_ramp_limit_regs.v]
// Purpose: APB register bank steering divider, doubler, VCO calibration start and ramp limiting
// Assumes: datapath inputs run on pclk; zero-wait-state APB access
// Notes: unmapped or misaligned addresses answer with pslverr, read zero, write nothing
//
// Added by the designer: register access over APB.
`include "synth_regs.vh"
`timescale 1ns/10ps
`default_nettype none
module synth_divider_ramp_limit_regs #(
   parameter ADDR_WIDTH   = 12,
   parameter CORE_DEFAULT = 2'h1,
   parameter AMP_DEFAULT  = 9'h080
) (
   input  wire                  pclk,
   input  wire                  presetn,
   input  wire                  psel,
   input  wire                  penable,
   input  wire                  pwrite,
   input  wire [ADDR_WIDTH-1:0] paddr,
   input  wire [31:0]           pwdata,
   output reg  [31:0]           prdata,
   output reg                   pready,
   output reg                   pslverr,
   // datapath side
   input  wire [32:0]           ramp_next,
   input  wire [1:0]            last_core,
   input  wire [7:0]            last_cap,
   input  wire [8:0]            last_amp,
   output reg  [15:0]           doubler_bias_out,
   output reg                   doubler_enable,
   output reg                   divider_buffer_enable,
   output reg  [9:0]            channel_divide_ratio,
   output reg                   ramp_active,
   output reg  [32:0]           ramp_offset,
   output reg                   recal_request,
   output reg  [1:0]            cal_start_core,
   output reg  [7:0]            cal_start_cap,
   output reg  [8:0]            cal_start_amp
);
   // stored fields
   reg        ramp_enable;
   reg [15:0] doubler_bias_word;
   reg        doubler_enable_bit;
   reg        divider_buffer_bit;
   reg [4:0]  channel_divide_code;
   reg        quick_recalibration;
   reg [7:0]  start_capacitor_code;
   reg [32:0] recal_threshold;
   reg [32:0] upper_limit;
   reg [32:0] lower_limit;
   reg [32:0] last_cal_point;
   reg        code_reserved;
   reg        buf_conflict;
   reg        cap_invalid;

   wire [9:0] ratio_dec;
   wire       reserved_dec;

   divide_ratio_decode u_decode (
      .code     (channel_divide_code),
      .ratio    (ratio_dec),
      .reserved (reserved_dec)
   );

   // address decode
   wire       aligned = (paddr[1:0] == 2'b00);
   wire [6:0] idx     = paddr[8:2];
   wire       upper_zero;
   generate
      if (ADDR_WIDTH > 9) begin : g_hi
         assign upper_zero = ~|paddr[ADDR_WIDTH-1:9];
      end else begin : g_nohi
         assign upper_zero = 1'b1;
      end
   endgenerate

   reg        mapped;
   reg [15:0] rd_word;

   always @* begin
      mapped  = 1'b1;
      rd_word = 16'h0000;
      case (idx)
         `IDX_RAMP_CTRL: rd_word[`POS_RAMP_EN] = ramp_enable;
         `IDX_DBL_BIAS:  rd_word = doubler_bias_word;
         `IDX_DBL_EN: begin
            rd_word = `FIX_DBL_EN;
            rd_word[`POS_DBL_EN] = doubler_enable_bit;
         end
         `IDX_DIV_BUF: begin
            rd_word = `FIX_DIV_BUF;
            rd_word[`POS_BUF_EN] = divider_buffer_bit;
         end
         `IDX_CH_DIV: begin
            rd_word = `FIX_CH_DIV;
            rd_word[`POS_DIV_LSB+4:`POS_DIV_LSB] = channel_divide_code;
         end
         `IDX_CAL_START: begin
            rd_word = `FIX_CAL_START;
            rd_word[`POS_THR_TOP] = recal_threshold[32];
            rd_word[`POS_QUICK] = quick_recalibration;
            rd_word[`POS_CAP_LSB+7:`POS_CAP_LSB] = start_capacitor_code;
         end
         `IDX_THR_MID: rd_word = recal_threshold[31:16];
         `IDX_THR_LOW: rd_word = recal_threshold[15:0];
         `IDX_UP_TOP:  rd_word[`POS_LIM_TOP] = upper_limit[32];
         `IDX_UP_MID:  rd_word = upper_limit[31:16];
         `IDX_UP_LOW:  rd_word = upper_limit[15:0];
         `IDX_LO_TOP:  rd_word[`POS_LIM_TOP] = lower_limit[32];
         `IDX_LO_MID:  rd_word = lower_limit[31:16];
         `IDX_LO_LOW:  rd_word = lower_limit[15:0];
         `IDX_STATUS: begin
            rd_word[`ST_RESERVED]     = code_reserved;
            rd_word[`ST_BUF_CONFLICT] = buf_conflict;
            rd_word[`ST_CAP_INVALID]  = cap_invalid;
            rd_word[`ST_RAMP_ACTIVE]  = ramp_active;
            rd_word[`ST_RATIO_LSB+9:`ST_RATIO_LSB] = channel_divide_ratio;
         end
         default: mapped = 1'b0;
      endcase
   end

   wire hit     = mapped & aligned & upper_zero;
   wire setup   = psel & ~penable;
   wire do_wr   = psel & penable & pready & pwrite & ~pslverr;
   wire status_ro = (idx == `IDX_STATUS);

   reg        next_pready;
   reg        next_pslverr;
   reg [31:0] next_prdata;

   // answer prepared in setup so the access phase completes at once
   always @* begin
      next_pready  = setup;
      next_pslverr = 1'b0;
      next_prdata  = prdata;
      if (setup) begin
         // refused transfers still complete, with an error and zero data
         next_pslverr = ~hit;
         next_prdata  = 32'h00000000;
         if (hit && !pwrite) begin
            next_prdata = {16'h0000, rd_word};
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= next_pready;
         pslverr <= next_pslverr;
         prdata  <= next_prdata;
      end
   end

   // register writes; fixed bits ignore write data
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ramp_enable          <= 1'b0;
         doubler_bias_word    <= `RST_DBL_BIAS;
         doubler_enable_bit   <= 1'b0;
         divider_buffer_bit   <= 1'b0;
         channel_divide_code  <= 5'h00;
         quick_recalibration  <= 1'b0;
         start_capacitor_code <= 8'h00;
         recal_threshold      <= 33'h000000000;
         upper_limit          <= 33'h000000000;
         lower_limit          <= 33'h000000000;
      end else if (do_wr && !status_ro) begin
         case (idx)
            `IDX_RAMP_CTRL: ramp_enable <= pwdata[`POS_RAMP_EN];
            `IDX_DBL_BIAS:  doubler_bias_word <= pwdata[15:0];
            `IDX_DBL_EN:    doubler_enable_bit <= pwdata[`POS_DBL_EN];
            `IDX_DIV_BUF:   divider_buffer_bit <= pwdata[`POS_BUF_EN];
            `IDX_CH_DIV:    channel_divide_code <= pwdata[`POS_DIV_LSB+4:`POS_DIV_LSB];
            `IDX_CAL_START: begin
               recal_threshold[32]  <= pwdata[`POS_THR_TOP];
               quick_recalibration  <= pwdata[`POS_QUICK];
               start_capacitor_code <= pwdata[`POS_CAP_LSB+7:`POS_CAP_LSB];
            end
            `IDX_THR_MID: recal_threshold[31:16] <= pwdata[15:0];
            `IDX_THR_LOW: recal_threshold[15:0]  <= pwdata[15:0];
            `IDX_UP_TOP:  upper_limit[32]        <= pwdata[`POS_LIM_TOP];
            `IDX_UP_MID:  upper_limit[31:16]     <= pwdata[15:0];
            `IDX_UP_LOW:  upper_limit[15:0]      <= pwdata[15:0];
            `IDX_LO_TOP:  lower_limit[32]        <= pwdata[`POS_LIM_TOP];
            `IDX_LO_MID:  lower_limit[31:16]     <= pwdata[15:0];
            `IDX_LO_LOW:  lower_limit[15:0]      <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // ramp offsets are 33-bit two's complement relative to the start frequency
   // limits are trusted: an upper limit below the lower one is not detected
   wire signed [32:0] next_s  = ramp_next;
   wire signed [32:0] upper_s = upper_limit;
   wire signed [32:0] lower_s = lower_limit;
   reg         [32:0] next_offset;

   always @* begin
      if (next_s > upper_s) begin
         next_offset = upper_limit;
      end else if (next_s < lower_s) begin
         next_offset = lower_limit;
      end else begin
         next_offset = ramp_next;
      end
   end

   // distance moved since the last calibration point
   wire [32:0] moved     = next_offset - last_cal_point;
   wire [32:0] moved_abs = moved[32] ? (33'h000000000 - moved) : moved;
   wire        need_cal  = (recal_threshold != 33'h000000000) && (moved_abs >= recal_threshold);

   wire        cap_over  = (start_capacitor_code > `CAP_MAX);

   // next values of the datapath-facing flops
   reg [15:0] next_doubler_bias_out;
   reg        next_buf_conflict;
   reg [32:0] next_ramp_offset;
   reg [32:0] next_last_cal_point;
   reg        next_recal_request;
   reg [1:0]  next_cal_start_core;
   reg [7:0]  next_cal_start_cap;
   reg [8:0]  next_cal_start_amp;

   // bias only reaches the doubler, idle when undoubled
   always @* begin
      next_doubler_bias_out = 16'h0000;
      if (doubler_enable_bit) begin
         next_doubler_bias_out = doubler_bias_word;
      end
   end

   // flags a setting the buffer cannot drive; not corrected in hardware
   always @* begin
      next_buf_conflict = 1'b0;
      if (!divider_buffer_bit && !reserved_dec) begin
         next_buf_conflict = (ratio_dec != `RATIO_TWO);
      end
   end

   // a disabled ramp forgets its calibration point so a restart measures from zero
   always @* begin
      next_ramp_offset    = 33'h000000000;
      next_last_cal_point = 33'h000000000;
      next_recal_request  = 1'b0;
      if (ramp_enable) begin
         next_ramp_offset    = next_offset;
         next_last_cal_point = last_cal_point;
         if (need_cal) begin
            next_recal_request  = 1'b1;
            next_last_cal_point = next_offset;
         end
      end
   end

   always @* begin
      if (quick_recalibration) begin
         next_cal_start_core = last_core;
         next_cal_start_cap  = last_cap;
         next_cal_start_amp  = last_amp;
      end else begin
         next_cal_start_core = CORE_DEFAULT[1:0];
         // out-of-range codes would pick a nonexistent band
         next_cal_start_cap  = cap_over ? `CAP_MAX : start_capacitor_code;
         next_cal_start_amp  = AMP_DEFAULT[8:0];
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         doubler_bias_out      <= 16'h0000;
         doubler_enable        <= 1'b0;
         divider_buffer_enable <= 1'b0;
         channel_divide_ratio  <= 10'h000;
         code_reserved         <= 1'b0;
         buf_conflict          <= 1'b0;
         cap_invalid           <= 1'b0;
         ramp_active           <= 1'b0;
         ramp_offset           <= 33'h000000000;
         last_cal_point        <= 33'h000000000;
         recal_request         <= 1'b0;
         cal_start_core        <= 2'h0;
         cal_start_cap         <= 8'h00;
         cal_start_amp         <= 9'h000;
      end else begin
         doubler_enable        <= doubler_enable_bit;
         doubler_bias_out      <= next_doubler_bias_out;
         divider_buffer_enable <= divider_buffer_bit;
         channel_divide_ratio  <= ratio_dec;
         code_reserved         <= reserved_dec;
         buf_conflict          <= next_buf_conflict;
         cap_invalid           <= cap_over;
         ramp_active           <= ramp_enable;
         ramp_offset           <= next_ramp_offset;
         last_cal_point        <= next_last_cal_point;
         recal_request         <= next_recal_request;
         cal_start_core        <= next_cal_start_core;
         cal_start_cap         <= next_cal_start_cap;
         cal_start_amp         <= next_cal_start_amp;
      end
   end
endmodule // synth_divider_ramp_limit_regs
`default_nettype wire

// [hw/synth_regs.vh]
// Purpose: register map constants for the synthesizer divider, doubler, calibration and ramp limit bank
// Assumes: register indices are word indices; byte address is four times the index
// Notes: multi-register fields keep their top bits in the lowest index
//
// Summary of operation
// - bias word 0x0624 reset, doubler enable gates it
// - divide code 0..17 maps ratios, rest reserved
// - ramp moved by threshold triggers recalibration
// - quick recalibration starts from last found values
// - start capacitor code 0..183, clamped otherwise
// - ramp limits act only with ramp enable
// - with ramp enable, ramp offset never exceeds an upper limit set at or above the lower one
// - with ramp enable, ramp offset never drops below a lower limit set at or below the upper one
`ifndef SYNTH_REGS_VH
`define SYNTH_REGS_VH

`define IDX_RAMP_CTRL       7'h00
`define IDX_DBL_BIAS        7'h19
`define IDX_DBL_EN          7'h1b
`define IDX_DIV_BUF         7'h1f
`define IDX_CH_DIV          7'h4b
`define IDX_CAL_START       7'h4e
`define IDX_THR_MID         7'h4f
`define IDX_THR_LOW         7'h50
`define IDX_UP_TOP          7'h51
`define IDX_UP_MID          7'h52
`define IDX_UP_LOW          7'h53
`define IDX_LO_TOP          7'h54
`define IDX_LO_MID          7'h55
`define IDX_LO_LOW          7'h56
`define IDX_STATUS          7'h7e

`define RST_DBL_BIAS        16'h0624
`define ALT_DBL_BIAS        16'h0c2b

`define FIX_DBL_EN          16'h0002
`define FIX_DIV_BUF         16'h03ec
`define FIX_CH_DIV          16'h0800
`define FIX_CAL_START       16'h0001

`define POS_RAMP_EN         15
`define POS_DBL_EN          0
`define POS_BUF_EN          14
`define POS_DIV_LSB         6
`define POS_THR_TOP         11
`define POS_QUICK           9
`define POS_CAP_LSB         1
`define POS_LIM_TOP         0

`define CAP_MAX             8'hb7
`define LAST_VALID_CODE     5'h11
`define RATIO_TWO           10'h002

`define ST_RESERVED         0
`define ST_BUF_CONFLICT     1
`define ST_CAP_INVALID      2
`define ST_RAMP_ACTIVE      3
`define ST_RATIO_LSB        4

`endif

// [hw/divide_ratio_decode.v]
// Purpose: maps the channel divide code onto its division ratio
// Assumes: purely combinational, registered by the caller
// Notes: reserved codes give ratio zero and raise the flag
`timescale 1ns/10ps
`default_nettype none
module divide_ratio_decode (
   input  wire [4:0] code,
   output reg  [9:0] ratio,
   output reg        reserved
);
   always @* begin
      reserved = 1'b0;
      case (code)
         5'h00:   ratio = 10'h002;
         5'h01:   ratio = 10'h004;
         5'h02:   ratio = 10'h006;
         5'h03:   ratio = 10'h008;
         5'h04:   ratio = 10'h00c;
         5'h05:   ratio = 10'h010;
         5'h06:   ratio = 10'h018;
         5'h07:   ratio = 10'h020;
         5'h08:   ratio = 10'h030;
         5'h09:   ratio = 10'h040;
         5'h0a:   ratio = 10'h048;
         5'h0b:   ratio = 10'h060;
         5'h0c:   ratio = 10'h080;
         5'h0d:   ratio = 10'h0c0;
         5'h0e:   ratio = 10'h100;
         5'h0f:   ratio = 10'h180;
         5'h10:   ratio = 10'h200;
         5'h11:   ratio = 10'h300;
         default: begin
            ratio    = 10'h000;
            reserved = 1'b1;
         end
      endcase
   end
endmodule // divide_ratio_decode
`default_nettype wire

// [dv/synth_regs_sva.sv]
// Purpose: port-level checks on the synthesizer register bank
// Assumes: one clock domain, asynchronous active-low reset
// Notes: datapath outputs trail their causes by one cycle
`timescale 1ns/10ps
`default_nettype none
module synth_regs_sva #(
   parameter CORE_DEFAULT = 2'h1,
   parameter AMP_DEFAULT  = 9'h080
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [1:0]  last_core,
   input wire logic [8:0]  last_amp,
   input wire logic [15:0] doubler_bias_out,
   input wire logic        doubler_enable,
   input wire logic [9:0]  channel_divide_ratio,
   input wire logic        ramp_active,
   input wire logic [32:0] ramp_offset,
   input wire logic        recal_request,
   input wire logic [1:0]  cal_start_core,
   input wire logic [7:0]  cal_start_cap,
   input wire logic [8:0]  cal_start_amp
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_ready_after_setup; psel && !penable |=> pready; endproperty
   a_ready_after_setup: assert property (p_ready_after_setup) else $error("ready missing after setup");
   property p_ready_only_after_setup; !(psel && !penable) |=> !pready; endproperty
   a_ready_only_after_setup: assert property (p_ready_only_after_setup) else $error("stray ready");
   property p_err_with_ready; pslverr |-> pready; endproperty
   a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
   property p_bias_gate; !doubler_enable |-> doubler_bias_out == 16'h0000; endproperty
   a_bias_gate: assert property (p_bias_gate) else $error("bias out while doubler off");
   property p_ratio_set; channel_divide_ratio inside {10'd0, 10'd2, 10'd4, 10'd6, 10'd8, 10'd12, 10'd16,
      10'd24, 10'd32, 10'd48, 10'd64, 10'd72, 10'd96, 10'd128, 10'd192, 10'd256, 10'd384, 10'd512, 10'd768};
   endproperty
   a_ratio_set: assert property (p_ratio_set) else $error("illegal divide ratio");
   property p_cap_max; cal_start_cap <= 8'hb7; endproperty
   a_cap_max: assert property (p_cap_max) else $error("start cap above 183");
   property p_start_vals; $past(presetn) |-> (cal_start_core == CORE_DEFAULT && cal_start_amp == AMP_DEFAULT)
      || (cal_start_core == $past(last_core) && cal_start_amp == $past(last_amp)); endproperty
   a_start_vals: assert property (p_start_vals) else $error("start values neither default nor last");
   property p_recal_active; recal_request |-> ramp_active; endproperty
   a_recal_active: assert property (p_recal_active) else $error("recal with ramp off");
   property p_recal_once; recal_request ##1 (ramp_active && $stable(ramp_offset)) |-> !recal_request; endproperty
   a_recal_once: assert property (p_recal_once) else $error("recal without ramp movement");
   property p_offset_off; !ramp_active |-> ramp_offset == 33'h0; endproperty
   a_offset_off: assert property (p_offset_off) else $error("offset while ramp off");
endmodule // synth_regs_sva
bind synth_divider_ramp_limit_regs synth_regs_sva #(.CORE_DEFAULT(CORE_DEFAULT), .AMP_DEFAULT(AMP_DEFAULT))
   synth_regs_sva_inst (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .last_core, .last_amp,
   .doubler_bias_out, .doubler_enable, .channel_divide_ratio, .ramp_active, .ramp_offset,
   .recal_request, .cal_start_core, .cal_start_cap, .cal_start_amp);
`default_nettype wire

// [dv/synth_divider_ramp_limit_regs_tb.sv]
// Purpose: self-checking bench for the synthesizer register bank
// Assumes: one-cycle APB answer, outputs one cycle behind registers
// Notes: ramp band is kept small so both limits clip often
`timescale 1ns/10ps
`default_nettype none
module synth_divider_ramp_limit_regs_tb;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rdata, seed = 32'd70;
   logic        pready, pslverr, err, doubler_enable, divider_buffer_enable, ramp_active, recal_request;
   logic [32:0] ramp_next = 0, ramp_offset;
   logic [1:0]  last_core = 0, cal_start_core;
   logic [7:0]  last_cap = 0, cal_start_cap;
   logic [8:0]  last_amp = 0, cal_start_amp;
   logic [15:0] doubler_bias_out;
   logic [9:0]  channel_divide_ratio;
   int          fail_count = 0, comparisons = 0;
   logic [9:0]  rt [18] = '{2, 4, 6, 8, 12, 16, 24, 32, 48, 64, 72, 96, 128, 192, 256, 384, 512, 768};
   logic [11:0] ra [13] = '{12'h064, 12'h06c, 12'h07c, 12'h12c, 12'h138, 12'h13c, 12'h140, 12'h144,
                            12'h148, 12'h14c, 12'h150, 12'h154, 12'h158};
   logic [15:0] rm [13] = '{16'hffff, 16'h0001, 16'h4000, 16'h07c0, 16'h0bfe, 16'hffff, 16'hffff,
                            16'h0001, 16'hffff, 16'hffff, 16'h0001, 16'hffff, 16'hffff};
   logic [15:0] rf [13] = '{16'h0, 16'h0002, 16'h03ec, 16'h0800, 16'h0001, 16'h0, 16'h0, 16'h0, 16'h0,
                            16'h0, 16'h0, 16'h0, 16'h0};
   // threshold 0x100, upper +0x300, lower -0x300
   logic [15:0] wd [9] = '{16'h0001, 16'h0, 16'h0100, 16'h0, 16'h0, 16'h0300, 16'h0001, 16'hffff, 16'hfd00};
   logic [7:0]  caps [8] = '{8'd0, 8'd5, 8'd183, 8'd40, 8'd184, 8'd9, 8'd255, 8'd1};
   localparam logic signed [32:0] up = 33'sh300;
   localparam logic signed [32:0] lo = -33'sh300;

   synth_divider_ramp_limit_regs #(.ADDR_WIDTH(12)) synth_divider_ramp_limit_regs_inst (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .ramp_next, .last_core, .last_cap, .last_amp, .doubler_bias_out, .doubler_enable,
      .divider_buffer_enable, .channel_divide_ratio, .ramp_active, .ramp_offset, .recal_request,
      .cal_start_core, .cal_start_cap, .cal_start_amp);

   always #5 pclk = ~pclk;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [9:0] ratio_of(input logic [4:0] c);
      return (c < 18) ? rt[c] : 10'h000;
   endfunction

   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rdata = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   task automatic settle();
      repeat (2) @(negedge pclk);
   endtask

   task automatic complete_run();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      #100000;
      fail_count++;
      complete_run();
   end

   initial begin
      logic [15:0]        r;
      logic signed [32:0] v, c, eo, last;
      logic signed [33:0] d;
      logic               er;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      settle();
      chk({channel_divide_ratio, doubler_bias_out}, {10'd2, 16'h0});
      chk({cal_start_core, cal_start_amp}, {2'h1, 9'h080});
      for (int i = 0; i < 13; i++) begin
         apb(0, ra[i], 0);
         chk(rdata, (i == 0) ? 32'h0624 : rf[i]);
         r = 16'(rnd());
         apb(1, ra[i], r);
         apb(0, ra[i], 0);
         chk(rdata, (r & rm[i]) | rf[i]);
      end
      apb(0, 12'h004, 0);
      chk({err, rdata}, {1'b1, 32'h0});
      apb(0, 12'h066, 0);
      chk({err, rdata}, {1'b1, 32'h0});
      apb(1, 12'h1f8, 16'hffff);
      chk(err, 0);
      apb(1, 12'h064, 16'h0c2b);
      apb(1, 12'h864, 16'h1234);
      chk(err, 1);
      apb(1, 12'h06c, 16'h0001);
      settle();
      chk({doubler_enable, doubler_bias_out}, {1'b1, 16'h0c2b});
      apb(1, 12'h06c, 16'h0000);
      settle();
      chk({doubler_enable, doubler_bias_out}, 0);
      for (int k = 0; k < 32; k++) begin
         apb(1, 12'h07c, 16'(k[0]) << 14);
         apb(1, 12'h12c, 16'(k) << 6);
         settle();
         chk({divider_buffer_enable, channel_divide_ratio}, {k[0], ratio_of(5'(k))});
         apb(0, 12'h1f8, 0);
         chk({rdata[13:3], rdata[1:0]}, {ratio_of(5'(k)), 1'b0, !k[0] && k > 0 && k < 18, k > 17});
      end
      foreach (caps[i]) begin
         @(posedge pclk);
         last_core <= 2'(rnd());
         last_cap <= 8'(rnd() % 184); // calibration only finds valid codes
         last_amp <= 9'(rnd());
         apb(1, 12'h138, {6'h00, i[0], caps[i], 1'b0});
         settle();
         if (i[0])
            chk({cal_start_core, cal_start_cap, cal_start_amp}, {last_core, last_cap, last_amp});
         else
            chk({cal_start_core, cal_start_cap, cal_start_amp}, {2'h1, (caps[i] > 183) ? 8'hb7 : caps[i], 9'h080});
         apb(0, 12'h1f8, 0);
         chk(rdata[2], caps[i] > 183);
      end
      foreach (wd[i])
         apb(1, 12'h138 + 12'(i * 4), wd[i]);
      for (int en = 0; en < 2; en++) begin
         @(posedge pclk);
         ramp_next <= 0;
         apb(1, 12'h000, 16'(en) << 15);
         settle();
         {eo, er, last} = 0;
         for (int i = 0; i < 60; i++) begin
            @(posedge pclk);
            // every fourth step repeats so a request meets a still offset
            if (i % 4 != 3)
               v = 33'(rnd() & 32'h7ff) - 33'sd1024;
            ramp_next <= v;
            @(negedge pclk);
            chk({ramp_active, recal_request, ramp_offset}, {en[0], er, eo});
            c = en ? ((v > up) ? up : (v < lo) ? lo : v) : 0;
            d = c - last;
            er = en && (d >= 256 || d <= -256);
            if (er) last = c;
            eo = c;
         end
      end
      complete_run();
   end
endmodule // synth_divider_ramp_limit_regs_tb
`default_nettype wire
